/* design/delayed_branch_sequencer.sv */
// Functional notes
// RULE1: keep the program counter and a next counter that is normally it plus four.
// RULE2: at instruction end copy next into current, then step by four or load target.
// RULE3: the delay instruction is what the next counter points at during a transfer.
// RULE4: taken transfer at 12 to 40 runs 8,12,16,40; untaken runs 8,12,16,20.
// RULE5: the annul flag counts only on conditional branches; ignored on other transfers.
// RULE6: untaken conditional branch with annul set annuls its delay instruction.
// RULE7: an annulled instruction changes no state and raises no trap.
// RULE8: a taken conditional branch executes its delay instruction regardless of annul.
// RULE9: branch-always with annul set annuls the delay slot though taken.
// RULE10: with annul clear the delay instruction always executes.
// RULE11: in a couple the first target is the second transfer's delay slot.
// RULE12: unconditional at 12 then taken at 16 runs 12,16,40,60,64.
// RULE13: couple second untaken, annul clear: execute 40, continue at 44.
// RULE14: couple second untaken, annul set: annul 40, continue at 44.
// RULE15: couple second branch-always, annul set: annul 40, go to 60.
// RULE16: first branch-always with annul set annuls second transfer; runs 12,40,44.
// RULE17: conditional-first couple is unsupported; continue somewhere, alter no other state.
// RULE18: trap-on-condition is non-delayed and never forms a couple.
// RULE19: jump-and-link then return-from-trap restores both counters; code ignores is_return_from_trap, loads them via load_counters.
// RULE20: register the annul decision on resolve; block writeback and traps for the slot.
`timescale 1ns/1ps
`default_nettype none

module delayed_branch_sequencer
#(
  parameter int AW = seq_pkg::ADDR_W
)
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // execute stage: the instruction at the program counter ends this cycle
  input  wire logic               instr_done,
  input  wire logic               is_transfer,
  input  wire logic               is_cond_branch,
  input  wire logic               is_branch_always,
  input  wire logic               is_trap_cond,
  input  wire logic               is_return_from_trap,
  input  wire logic               annul_flag,
  input  wire logic               taken,
  input  wire logic [AW-1:0]      target_addr,
  input  wire logic               wb_request,
  input  wire logic               trap_request,
  // trap entry loads both counters from outside
  input  wire logic               load_counters,
  input  wire logic [AW-1:0]      load_pc,
  input  wire logic [AW-1:0]      load_next_pc,
  // fetch path and status
  output logic [AW-1:0]           program_counter,
  output logic [AW-1:0]           next_program_counter,
  output logic [AW-1:0]           fetch_addr,
  output logic                    slot_annulled,
  output seq_pkg::slot_kind_t     slot_kind,
  output logic                    wb_enable,
  output logic                    trap_enable,
  output logic                    couple_seen,
  output logic                    unsupported_couple,
  output logic                    misaligned_target
);

  import seq_pkg::*;

  logic [AW-1:0] pc_q;
  logic [AW-1:0] pc_d;
  logic [AW-1:0] npc_q;
  logic [AW-1:0] npc_d;
  logic          annul_q;
  logic          annul_d;
  logic          annul_raw;
  logic          live_transfer;
  logic          prev_transfer_q;
  logic          prev_cond_q;
  slot_kind_t    kind_q;
  slot_kind_t    kind_d;
  logic          couple_q;
  logic          bad_couple_q;
  logic          misalign_q;
  logic [AW-1:0] step_addr;

  localparam logic [AW-1:0] STEP     = AW'(INSTR_STEP);
  localparam logic [AW-1:0] PC_INIT  = AW'(RESET_PC);
  localparam logic [AW-1:0] NPC_INIT = AW'(RESET_NPC);

  // an annulled instruction or a trap-on-condition never acts as a delayed transfer
  assign live_transfer = is_transfer && !is_trap_cond && !annul_q;   // see RULE18 see RULE16

  // sequential successor of the next counter
  assign step_addr = npc_q + STEP;                                    // see RULE1

  // annul decision for the slot that follows the current instruction
  annul_decider u_annul
  (
    .is_transfer      (live_transfer),
    .is_cond_branch   (is_cond_branch),
    .is_branch_always (is_branch_always),
    .annul_flag       (annul_flag),
    .taken            (taken),
    .annul_slot       (annul_raw)
  );

  // next values of the counters
  always_comb
  begin
    pc_d    = pc_q;
    npc_d   = npc_q;
    annul_d = annul_q;
    if (load_counters)
    begin
      pc_d    = load_pc;
      npc_d   = load_next_pc;
      annul_d = 1'b0;
    end
    else if (instr_done)
    begin
      pc_d    = npc_q;                                                // see RULE2 see RULE3
      annul_d = annul_raw;                                            // see RULE20
      if (live_transfer && taken)
        npc_d = target_addr;                                          // see RULE4 see RULE11
      else
        npc_d = step_addr;                                            // see RULE13 see RULE14
    end
  end

  // counters update once per finished instruction
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pc_q  <= PC_INIT;
      npc_q <= NPC_INIT;
    end
    else
    begin
      pc_q  <= pc_d;                                                  // see RULE12 see RULE15
      npc_q <= npc_d;                                                 // see RULE19
    end
  end

  // registered annul decision applies to the instruction that becomes current
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      annul_q <= 1'b0;
    else
      annul_q <= annul_d;                                             // see RULE20
  end

  // remember what the previous live instruction was, to recognise couples
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prev_transfer_q <= 1'b0;
      prev_cond_q     <= 1'b0;
    end
    else if (load_counters)
    begin
      prev_transfer_q <= 1'b0;
      prev_cond_q     <= 1'b0;
    end
    else if (instr_done)
    begin
      prev_transfer_q <= live_transfer;
      prev_cond_q     <= live_transfer && is_cond_branch && !is_branch_always;
    end
  end

  // classify the slot that becomes current
  always_comb
  begin
    kind_d = kind_q;
    if (load_counters)
      kind_d = SLOT_PLAIN;
    else if (instr_done)
    begin
      if (annul_raw)
        kind_d = SLOT_ANNULLED;
      else if (live_transfer && prev_transfer_q)
        kind_d = SLOT_COUPLE_DELAY;                                   // see RULE11
      else if (live_transfer)
        kind_d = SLOT_DELAY;                                          // see RULE3
      else
        kind_d = SLOT_PLAIN;
    end
  end

  // slot kind register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      kind_q <= SLOT_PLAIN;
    else
      kind_q <= kind_d;
  end

  // couple status: seen, and the unsupported conditional-first case
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      couple_q     <= 1'b0;
      bad_couple_q <= 1'b0;
    end
    else if (load_counters)
    begin
      couple_q     <= 1'b0;
      bad_couple_q <= 1'b0;
    end
    else if (instr_done)
    begin
      couple_q     <= live_transfer && prev_transfer_q;
      bad_couple_q <= live_transfer && prev_cond_q;                   // see RULE17
    end
  end

  // flag a taken transfer whose target is not word aligned
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      misalign_q <= 1'b0;
    else if (load_counters)
      misalign_q <= 1'b0;                                             // load wins over a transfer
    else if (instr_done && live_transfer && taken)
      misalign_q <= |target_addr[ALIGN_BITS-1:0];
    else if (instr_done)
      misalign_q <= 1'b0;
  end

  // an annulled slot writes nothing back and raises no trap
  assign wb_enable   = instr_done && wb_request && !annul_q;          // see RULE7 see RULE20
  assign trap_enable = trap_request && !annul_q;                      // see RULE7 see RULE20

  // outputs
  assign program_counter      = pc_q;
  assign next_program_counter = npc_q;
  assign fetch_addr           = npc_q;
  assign slot_annulled        = annul_q;
  assign slot_kind            = kind_q;
  assign couple_seen          = couple_q;
  assign unsupported_couple   = bad_couple_q;
  assign misaligned_target    = misalign_q;

endmodule : delayed_branch_sequencer

`default_nettype wire

/* design/seq_pkg.sv */
// shared constants and types for the program-counter sequencer
package seq_pkg;

  localparam int          ADDR_W      = 32;
  // byte distance between two sequential instructions
  localparam logic [31:0] INSTR_STEP  = 32'h0000_0004;
  // program counter after reset
  localparam logic [31:0] RESET_PC    = 32'h0000_0000;
  // next program counter after reset
  localparam logic [31:0] RESET_NPC   = 32'h0000_0004;
  // low address bits that must be zero for a word-aligned target
  localparam int          ALIGN_BITS  = 2;

  // where the instruction now at the program counter stands in a transfer chain
  typedef enum logic [1:0]
  {
    SLOT_PLAIN,
    SLOT_DELAY,
    SLOT_COUPLE_DELAY,
    SLOT_ANNULLED
  } slot_kind_t;

endpackage : seq_pkg

/* design/annul_decider.sv */
`timescale 1ns/1ps
`default_nettype none

// decides whether the delay instruction of a transfer must be annulled
module annul_decider
(
  input  wire logic is_transfer,
  input  wire logic is_cond_branch,
  input  wire logic is_branch_always,
  input  wire logic annul_flag,
  input  wire logic taken,
  output logic      annul_slot
);

  // the flag counts on conditional branches only; always-branches annul when set,
  // other conditional branches annul only when untaken
  always_comb
  begin
    annul_slot = 1'b0;
    if (is_transfer && is_cond_branch && annul_flag)                  // see RULE5
    begin
      if (is_branch_always)
        annul_slot = 1'b1;                                            // see RULE9
      else if (!taken)
        annul_slot = 1'b1;                                            // see RULE6
      else
        annul_slot = 1'b0;                                            // see RULE8
    end
  end                                                                 // see RULE10

endmodule : annul_decider

`default_nettype wire

/* tb/instr_store_model.sv */
`timescale 1ns/1ps
`default_nettype none

// instruction store: each word holds decoded transfer fields and a target
module instr_store_model
(
  input  wire logic [31:0] addr,
  output logic [5:0]       code,
  output logic [31:0]      tgt
);
  logic [5:0]  code_q [64] = '{default: 6'h00};
  logic [31:0] tgt_q  [64] = '{default: 32'h0};
  // word read follows the program counter with no wait states
  assign code = code_q[addr[7:2]];
  assign tgt  = tgt_q[addr[7:2]];
endmodule : instr_store_model

`default_nettype wire

/* tb/seq_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// watches counter sequencing and delay-slot annulment
module seq_checker_asserts
#(
  parameter int AW = 32
)
(
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic          instr_done,
  input wire logic          is_transfer,
  input wire logic          is_cond_branch,
  input wire logic          is_branch_always,
  input wire logic          is_trap_cond,
  input wire logic          annul_flag,
  input wire logic          taken,
  input wire logic          load_counters,
  input wire logic [AW-1:0] target_addr,
  input wire logic [AW-1:0] program_counter,
  input wire logic [AW-1:0] next_program_counter,
  input wire logic [AW-1:0] fetch_addr,
  input wire logic          slot_annulled,
  input wire logic          wb_enable,
  input wire logic          trap_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a live instruction ends, then the same as a live transfer
  sequence s_live;
    instr_done && !load_counters && !slot_annulled && !is_trap_cond;
  endsequence
  sequence s_xfer;
    s_live ##0 is_transfer;
  endsequence
  property p_step;
    s_live ##0 !is_transfer |=> program_counter == $past(next_program_counter)
      && next_program_counter == $past(next_program_counter) + 32'h4;
  endproperty
  a_step: assert property (p_step) else $error("plain step wrong");
  property p_taken;
    s_xfer ##0 taken |=> next_program_counter == $past(target_addr)
      && program_counter == $past(next_program_counter);
  endproperty
  a_taken: assert property (p_taken) else $error("target not loaded");
  property p_annul;
    s_xfer ##0 is_cond_branch && annul_flag && (is_branch_always || !taken) |=> slot_annulled;
  endproperty
  a_annul: assert property (p_annul) else $error("slot not annulled");
  property p_keep;
    s_xfer ##0 !(is_cond_branch && annul_flag && (is_branch_always || !taken))
      |=> !slot_annulled;
  endproperty
  a_keep: assert property (p_keep) else $error("slot wrongly annulled");
  property p_quiet;
    slot_annulled |-> !wb_enable && !trap_enable;
  endproperty
  a_quiet: assert property (p_quiet) else $error("annulled slot acts");
  property p_trap;
    instr_done && !load_counters && !slot_annulled && is_trap_cond
      |=> !slot_annulled && next_program_counter == $past(next_program_counter) + 32'h4;
  endproperty
  a_trap: assert property (p_trap) else $error("trap word delayed");
  property p_skip;
    instr_done && !load_counters && slot_annulled
      |=> !slot_annulled && next_program_counter == $past(next_program_counter) + 32'h4;
  endproperty
  a_skip: assert property (p_skip) else $error("annulled word acted");
  property p_fetch;
    fetch_addr == next_program_counter;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch off counter");
endmodule : seq_checker_asserts

bind delayed_branch_sequencer seq_checker_asserts #(.AW(AW)) i_seq_checker_asserts (.*);

`default_nettype wire

/* tb/delayed_branch_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module delayed_branch_sequencer_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instr_done = 1'b0;
  logic        req = 1'b0;
  logic [5:0]  dec = 6'h00;
  logic [31:0] target_addr = 32'h0;
  logic [31:0] program_counter;
  logic [5:0]  code;
  logic [31:0] tgt;
  logic        slot_annulled;
  logic        wb_enable;
  logic        trap_enable;
  logic        load_counters = 1'b0;
  logic [31:0] load_pc = 32'h0;
  logic [31:0] load_next_pc = 32'h0;
  logic [31:0] next_program_counter;
  logic [31:0] fetch_addr;
  logic [1:0]  slot_kind;
  logic        couple_seen;
  logic        unsupported_couple;
  logic        misaligned_target;
  int          errors = 0;
  int          check_count = 0;

  always #25 ref_clk = ~ref_clk;

  delayed_branch_sequencer i_delayed_branch_sequencer
  (
    .ref_clk, .rst_n, .instr_done, .target_addr, .program_counter, .slot_annulled,
    .wb_enable, .trap_enable, .is_trap_cond(dec[5]), .is_transfer(dec[4]),
    .is_cond_branch(dec[3]), .is_branch_always(dec[2]), .annul_flag(dec[1]),
    .taken(dec[0]), .wb_request(req), .trap_request(req), .is_return_from_trap(1'b0),
    .load_counters, .load_pc, .load_next_pc, .next_program_counter,
    .fetch_addr, .slot_kind, .couple_seen, .unsupported_couple,
    .misaligned_target
  );
  instr_store_model i_instr_store_model (.addr(program_counter), .code, .tgt);

  task automatic test_done();
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  // ends one word; seen is its address with bit 0 marking an annulled slot
  task automatic step(output logic [31:0] seen);
    @(negedge ref_clk);
    seen = program_counter | {31'h0, slot_annulled};
    @(posedge ref_clk);
    instr_done <= 1'b1;
    req <= 1'b1;
    dec <= code;
    target_addr <= tgt;
    @(negedge ref_clk);
    cmp32({30'h0, wb_enable, trap_enable}, {30'h0, !slot_annulled, !slot_annulled});
    @(posedge ref_clk);
    instr_done <= 1'b0;
    req <= 1'b0;
  endtask : step

  // words at 12 and 16 jump to 40 and 60; order is compared from 12 on
  task automatic one(input logic [5:0] c3, input logic [5:0] c4, input int n,
                     input logic [63:0] e);
    logic [31:0] seen;
    for (int i = 0; i < 64; i++)
      i_instr_store_model.code_q[i] = 6'h00;
    i_instr_store_model.code_q[3] = c3;
    i_instr_store_model.code_q[4] = c4;
    i_instr_store_model.tgt_q[3] = 32'h28;
    i_instr_store_model.tgt_q[4] = 32'h3C;
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) step(seen);
    for (int i = 0; i < n; i++)
    begin
      step(seen);
      cmp32(seen, {24'h0, e[8*(n-1-i) +: 8]});
    end
  endtask : one

  task automatic sc_single();
    one(6'h11, 6'h00, 4, 64'h0C10282C);
    one(6'h18, 6'h00, 4, 64'h0C101418);
  endtask : sc_single

  task automatic sc_annul();
    one(6'h1A, 6'h00, 4, 64'h0C111418);
    one(6'h1B, 6'h00, 4, 64'h0C10282C);
    one(6'h1F, 6'h00, 4, 64'h0C11282C);
    one(6'h13, 6'h00, 4, 64'h0C10282C);
    one(6'h1D, 6'h00, 4, 64'h0C10282C);
  endtask : sc_annul

  task automatic sc_couple();
    one(6'h11, 6'h11, 5, 64'h0C10283C40);
    one(6'h11, 6'h18, 4, 64'h0C10282C);
    one(6'h11, 6'h1A, 5, 64'h0C10292C30);
    one(6'h11, 6'h1F, 5, 64'h0C10293C40);
    one(6'h1F, 6'h11, 4, 64'h0C11282C);
  endtask : sc_couple

  task automatic sc_trap();
    one(6'h31, 6'h00, 4, 64'h0C101418);
  endtask : sc_trap

  // couple flags, the unsupported couple and a misaligned target load
  task automatic sc_flags();
    logic [31:0] seen;
    one(6'h11, 6'h11, 2, 64'h0C10);
    @(negedge ref_clk);
    cmp32({28'h0, couple_seen, unsupported_couple, slot_kind},
          {28'h0, 2'b10, seq_pkg::SLOT_COUPLE_DELAY});
    one(6'h19, 6'h11, 2, 64'h0C10);
    @(negedge ref_clk);
    cmp32({28'h0, couple_seen, unsupported_couple, slot_kind},
          {28'h0, 2'b11, seq_pkg::SLOT_COUPLE_DELAY});
    i_instr_store_model.code_q[10] = 6'h11;
    i_instr_store_model.tgt_q[10] = 32'h3E;
    step(seen);
    @(negedge ref_clk);
    cmp32(next_program_counter, 32'h3E);
    cmp32(fetch_addr, 32'h3E);
    cmp32({31'h0, misaligned_target}, 32'h1);
  endtask : sc_flags

  // both counters restored as a trap return does, then the run goes on from them
  task automatic sc_restore();
    logic [31:0] seen;
    @(posedge ref_clk);
    load_counters <= 1'b1;
    load_pc <= 32'h10;
    load_next_pc <= 32'h28;
    @(posedge ref_clk);
    load_counters <= 1'b0;
    @(negedge ref_clk);
    cmp32(program_counter, 32'h10);
    cmp32(next_program_counter, 32'h28);
    step(seen);
    step(seen);
    cmp32(seen, 32'h28);
  endtask : sc_restore

  initial
  begin
    sc_single();
    sc_annul();
    sc_couple();
    sc_trap();
    sc_flags();
    sc_restore();
    test_done();
  end

  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    test_done();
  end
endmodule : delayed_branch_sequencer_tb_top

`default_nettype wire
